// ===== design/ivam_pkg.sv
// Package for the interrupt vector address map block.
// Assumes a 20-bit byte address space and a 16-bit data path to memory.
package ivam_pkg;
	localparam int         ADDR_W        = 20;
	localparam logic [19:0] FIX_UNDEF    = 20'hfffdc;
	localparam logic [19:0] FIX_OVF      = 20'hfffe0;
	localparam logic [19:0] FIX_BREAK      = 20'hfffe4;
	localparam logic [19:0] FIX_BREAK_FLAG = 20'hfffe6;
	localparam logic [19:0] FIX_AMATCH     = 20'hfffe8;
	localparam logic [19:0] FIX_SSTEP      = 20'hfffec;
	localparam logic [19:0] FIX_WDT        = 20'hffff0;
	localparam logic [19:0] FIX_DEBUG      = 20'hffff4;
	localparam logic [19:0] FIX_NMI        = 20'hffff8;
	localparam logic [19:0] FIX_RESET      = 20'hffffc;
	localparam logic [7:0]  BREAK_REDIRECT = 8'hff;
	localparam logic [19:0] ENTRY_BYTES    = 20'h00004;
	localparam logic [19:0] WORD_STEP      = 20'h00002;
	localparam logic [19:0] BYTE_STEP      = 20'h00001;
	localparam logic [1:0]  WORD_LAST      = 2'h1;
	localparam logic [1:0]  BYTE_LAST      = 2'h3;
	localparam logic [5:0]  SWN_BREAK_ALT  = 6'h00;

	typedef enum logic [5:0] {
		SRC_SWINT, SRC_UNDEF, SRC_OVF, SRC_BREAK, SRC_AMATCH, SRC_SSTEP,
		SRC_WDT, SRC_OSC_STOP, SRC_VMON2, SRC_DEBUG, SRC_NMI, SRC_RESET,
		SRC_EXT0, SRC_EXT1, SRC_EXT2, SRC_EXT_THREE, SRC_EXT_FOUR,
		SRC_EXT_FIVE, SRC_SER2_COLL, SRC_TASKMON, SRC_DMA0, SRC_DMA1,
		SRC_KEY, SRC_ADC, SRC_SER2_TX, SRC_SER2_NACK, SRC_SER2_RX,
		SRC_SER2_ACK, SRC_SER0_TX, SRC_SER0_RX, SRC_SER1_TX, SRC_SER1_RX,
		SRC_TMRA0, SRC_TMRA1, SRC_TMRA2, SRC_TMRA3, SRC_TMRA4,
		SRC_TMRB0, SRC_TMRB1, SRC_TMRB2
	} ivam_src_t;

	typedef struct packed {
		ivam_src_t  src;
		logic [5:0] swint_num;
	} ivam_req_t;

	typedef struct packed {
		logic [19:0] addr;
		logic        word;
	} ivam_mem_t;
endpackage : ivam_pkg

// ===== design/ivam_vector_map.sv
// Vector address generation and vector fetch for the CPU interrupt sequencer.
// Assumes memory answers mem_ack_i one or more cycles after a request; all
// inputs are synchronous to core_clk_i.
`timescale 1ns/1ps
module ivam_vector_map (
	input  wire logic               core_clk_i,
	input  wire logic               reset_i,
	input  wire logic               req_valid_i,
	output logic                    req_ready_o,
	input  wire ivam_pkg::ivam_req_t req_i,
	input  wire logic [19:0]        vector_table_base_i,
	output logic                    mem_req_o,
	output ivam_pkg::ivam_mem_t     mem_o,
	input  wire logic               mem_ack_i,
	input  wire logic [15:0]        mem_rdata_i,
	output logic                    done_o,
	output logic [19:0]             vec_addr_o,
	output logic [19:0]             target_o
);
	import ivam_pkg::*;

	// ----------------------------------------
	// Source to vector mapping
	// ----------------------------------------
	function automatic logic [5:0] swnum_of(input ivam_src_t s, input logic [5:0] n);
		case (s)
			SRC_EXT_THREE: swnum_of = 6'h04;
			SRC_EXT_FIVE:  swnum_of = 6'h08;
			SRC_EXT_FOUR:  swnum_of = 6'h09;
			SRC_SER2_COLL, SRC_TASKMON: swnum_of = 6'h0a;
			SRC_DMA0:      swnum_of = 6'h0b;
			SRC_DMA1:      swnum_of = 6'h0c;
			SRC_KEY:       swnum_of = 6'h0d;
			SRC_ADC:       swnum_of = 6'h0e;
			SRC_SER2_TX, SRC_SER2_NACK: swnum_of = 6'h0f;
			SRC_SER2_RX, SRC_SER2_ACK:  swnum_of = 6'h10;
			SRC_SER0_TX:   swnum_of = 6'h11;
			SRC_SER0_RX:   swnum_of = 6'h12;
			SRC_SER1_TX:   swnum_of = 6'h13;
			SRC_SER1_RX:   swnum_of = 6'h14;
			SRC_TMRA0:     swnum_of = 6'h15;
			SRC_TMRA1:     swnum_of = 6'h16;
			SRC_TMRA2:     swnum_of = 6'h17;
			SRC_TMRA3:     swnum_of = 6'h18;
			SRC_TMRA4:     swnum_of = 6'h19;
			SRC_TMRB0:     swnum_of = 6'h1a;
			SRC_TMRB1:     swnum_of = 6'h1b;
			SRC_TMRB2:     swnum_of = 6'h1c;
			SRC_EXT0:      swnum_of = 6'h1d;
			SRC_EXT1:      swnum_of = 6'h1e;
			SRC_EXT2:      swnum_of = 6'h1f;
			// Numbers 1-3 and 5-7 are reachable only by software
			default:       swnum_of = n;
		endcase
	endfunction : swnum_of

	logic        is_fixed;
	logic [19:0] fixed_addr;
	logic [19:0] reloc_addr;
	logic [5:0]  swnum;

	always_comb begin
		is_fixed = 1'b1;
		swnum    = swnum_of(req_i.src, req_i.swint_num);
		case (req_i.src)
			SRC_UNDEF:  fixed_addr = FIX_UNDEF;
			SRC_OVF:    fixed_addr = FIX_OVF;
			SRC_BREAK:  fixed_addr = FIX_BREAK;
			SRC_AMATCH: fixed_addr = FIX_AMATCH;
			SRC_SSTEP:  fixed_addr = FIX_SSTEP;
			SRC_WDT, SRC_OSC_STOP, SRC_VMON2: fixed_addr = FIX_WDT;
			SRC_DEBUG:  fixed_addr = FIX_DEBUG;
			SRC_NMI:    fixed_addr = FIX_NMI;
			SRC_RESET:  fixed_addr = FIX_RESET;
			default: begin
				fixed_addr = FIX_RESET;
				is_fixed   = 1'b0;
			end
		endcase
		// 64 entries of four bytes span the 256-byte table
		reloc_addr = vector_table_base_i + {12'h000, swnum, 2'b00};
	end

	// ----------------------------------------
	// Fetch sequencer
	// ----------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_BREAK_CHK, ST_FETCH, ST_DONE} ivam_state_t;

	ivam_state_t state_reg, state_next;
	logic [19:0] cur_reg, cur_next;
	logic [19:0] vec_reg, vec_next;
	logic        word_reg, word_next;
	logic [1:0]  beat_reg, beat_next;
	logic [31:0] entry_reg, entry_next;
	logic [1:0]  last_beat;

	assign req_ready_o = (state_reg == ST_IDLE);
	assign mem_req_o   = (state_reg == ST_BREAK_CHK) || (state_reg == ST_FETCH);
	assign mem_o.addr  = cur_reg;
	assign mem_o.word  = word_reg && (state_reg == ST_FETCH);
	assign done_o      = (state_reg == ST_DONE);
	assign vec_addr_o  = vec_reg;
	// High byte may carry ID or option data, so it never reaches the PC
	assign target_o    = entry_reg[19:0];
	assign last_beat   = word_reg ? WORD_LAST : BYTE_LAST;

	always_comb begin
		state_next = state_reg;
		cur_next   = cur_reg;
		vec_next   = vec_reg;
		word_next  = word_reg;
		beat_next  = beat_reg;
		entry_next = entry_reg;
		case (state_reg)
			ST_IDLE: begin
				if (req_valid_i) begin
					beat_next  = 2'h0;
					entry_next = 32'h0000_0000;
					if (is_fixed) begin
						vec_next  = fixed_addr;
						word_next = 1'b1;
						cur_next   = (req_i.src == SRC_BREAK) ? FIX_BREAK_FLAG : fixed_addr;
						state_next = (req_i.src == SRC_BREAK) ? ST_BREAK_CHK : ST_FETCH;
					end else begin
						vec_next   = reloc_addr;
						cur_next   = reloc_addr;
						word_next  = ~vector_table_base_i[0];
						state_next = ST_FETCH;
					end
				end
			end
			ST_BREAK_CHK: begin
				if (mem_ack_i) begin
					state_next = ST_FETCH;
					if (mem_rdata_i[7:0] == BREAK_REDIRECT) begin
						vec_next  = vector_table_base_i + {12'h000, SWN_BREAK_ALT, 2'b00};
						cur_next  = vector_table_base_i + {12'h000, SWN_BREAK_ALT, 2'b00};
						word_next = ~vector_table_base_i[0];
					end else begin
						cur_next = vec_reg;
					end
				end
			end
			ST_FETCH: begin
				if (mem_ack_i) begin
					// Ascending addresses carry ascending significance
					if (word_reg) begin
						entry_next[{beat_reg[0], 4'h0} +: 16] = mem_rdata_i;
					end else begin
						entry_next[{beat_reg, 3'h0} +: 8] = mem_rdata_i[7:0];
					end
					cur_next  = cur_reg + (word_reg ? WORD_STEP : BYTE_STEP);
					beat_next = beat_reg + 2'h1;
					if (beat_reg == last_beat) begin
						state_next = ST_DONE;
					end
				end
			end
			ST_DONE: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state_reg <= ST_IDLE;
			cur_reg   <= 20'h00000;
			vec_reg   <= 20'h00000;
			word_reg  <= 1'b0;
			beat_reg  <= 2'h0;
			entry_reg <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
			cur_reg   <= cur_next;
			vec_reg   <= vec_next;
			word_reg  <= word_next;
			beat_reg  <= beat_next;
			entry_reg <= entry_next;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [2:0] bytes_seen_reg;
	always_ff @(posedge core_clk_i) begin
		if (reset_i || state_reg == ST_IDLE) begin
			bytes_seen_reg <= 3'h0;
		end else if (state_reg == ST_FETCH && mem_ack_i) begin
			bytes_seen_reg <= bytes_seen_reg + (word_reg ? 3'h2 : 3'h1);
		end
	end

	wire accept = req_valid_i && req_ready_o;
	// Offset below 256 bytes and four-byte aligned
	localparam logic [19:0] RELOC_OFS_MASK = 20'hfff03;

	chk_entry_four_bytes: assert property (@(posedge core_clk_i) disable iff (reset_i)
		done_o |-> bytes_seen_reg == 3'h4) else $error("entry not four bytes");
	chk_target_from_entry: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(state_reg == ST_FETCH && mem_ack_i && word_reg && beat_reg == WORD_LAST)
		|=> done_o && target_o[19:16] == $past(mem_rdata_i[3:0])) else $error("target mismatch");
	chk_fixed_nmi_reset: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && req_i.src inside {SRC_NMI, SRC_RESET}
		|=> vec_reg == (($past(req_i.src) == SRC_RESET) ? FIX_NMI + ENTRY_BYTES : FIX_NMI))
		else $error("nmi or reset vector wrong");
	chk_fixed_traps: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && req_i.src == SRC_UNDEF |=> mem_req_o && mem_o.addr == FIX_UNDEF)
		else $error("undefined opcode vector wrong");
	chk_shared_fixed: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && req_i.src inside {SRC_WDT, SRC_OSC_STOP, SRC_VMON2}
		|=> vec_reg == FIX_WDT) else $error("shared fixed vector wrong");
	chk_break_redirect: assert property (@(posedge core_clk_i) disable iff (reset_i)
		state_reg == ST_BREAK_CHK && mem_ack_i && mem_rdata_i[7:0] == BREAK_REDIRECT
		|=> mem_o.addr == vector_table_base_i) else $error("break redirect missed");
	chk_break_flag_read: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && req_i.src == SRC_BREAK
		|=> mem_req_o && !mem_o.word && mem_o.addr == FIX_BREAK_FLAG)
		else $error("break flag byte not read");
	chk_break_plain: assert property (@(posedge core_clk_i) disable iff (reset_i)
		state_reg == ST_BREAK_CHK && mem_ack_i && mem_rdata_i[7:0] != BREAK_REDIRECT
		|=> vec_reg == FIX_BREAK && mem_o.addr == FIX_BREAK) else $error("break vector wrong");
	chk_overflow_trap: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && req_i.src == SRC_OVF |=> vec_reg == FIX_OVF && mem_o.addr == FIX_OVF)
		else $error("overflow vector wrong");
	chk_even_base_words: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && !is_fixed && !vector_table_base_i[0] |=> mem_o.word)
		else $error("even base fetched by bytes");
	chk_reloc_window: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && !is_fixed
		|=> ((vec_reg - $past(vector_table_base_i)) & RELOC_OFS_MASK) == 20'h00000)
		else $error("entry outside relocatable table");
	chk_pin_four_five: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && req_i.src inside {SRC_EXT_FOUR, SRC_EXT_FIVE}
		|-> swnum == ((req_i.src == SRC_EXT_FIVE) ? 6'h08 : 6'h09))
		else $error("pin four or five number wrong");
	chk_shared_ten: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && req_i.src inside {SRC_SER2_COLL, SRC_TASKMON} |-> swnum == 6'h0a)
		else $error("collision or task monitor number wrong");
	chk_dma_numbers: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && req_i.src inside {SRC_DMA0, SRC_DMA1}
		|-> swnum == ((req_i.src == SRC_DMA0) ? 6'h0b : 6'h0c))
		else $error("dma number wrong");
	chk_key_adc: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && req_i.src inside {SRC_KEY, SRC_ADC}
		|-> swnum == ((req_i.src == SRC_KEY) ? 6'h0d : 6'h0e))
		else $error("key or converter number wrong");
	chk_serial2_shared: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && req_i.src inside {SRC_SER2_TX, SRC_SER2_NACK, SRC_SER2_RX, SRC_SER2_ACK}
		|-> swnum == ((req_i.src inside {SRC_SER2_TX, SRC_SER2_NACK}) ? 6'h0f : 6'h10))
		else $error("serial2 number wrong");
	chk_serial0_1: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && req_i.src inside {[SRC_SER0_TX:SRC_SER1_RX]}
		|-> swnum == 6'h11 + 6'(req_i.src - SRC_SER0_TX))
		else $error("serial0 or serial1 number wrong");
	chk_timer_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && req_i.src inside {[SRC_TMRA0:SRC_TMRA4]}
		|-> swnum == 6'h15 + 6'(req_i.src - SRC_TMRA0))
		else $error("timer A number wrong");
	chk_timer_b: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && req_i.src inside {[SRC_TMRB0:SRC_TMRB2]}
		|-> swnum == 6'h1a + 6'(req_i.src - SRC_TMRB0))
		else $error("timer B number wrong");
	chk_ext_low_pins: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && req_i.src inside {[SRC_EXT0:SRC_EXT2]}
		|-> swnum == 6'h1d + 6'(req_i.src - SRC_EXT0))
		else $error("pin zero to two number wrong");
	chk_reserved_free: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && !is_fixed && req_i.src != SRC_SWINT
		|-> !(swnum inside {[6'h01:6'h03], [6'h05:6'h07]}))
		else $error("hardware source on reserved number");
	chk_odd_base_bytes: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && !is_fixed && vector_table_base_i[0] |=> !mem_o.word)
		else $error("odd base fetched by words");
	chk_reloc_index: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && req_i.src == SRC_SWINT
		|=> vec_reg == $past(vector_table_base_i) + {12'h000, $past(req_i.swint_num), 2'b00})
		else $error("relocatable index wrong");
	chk_pin_three: assert property (@(posedge core_clk_i) disable iff (reset_i)
		accept && req_i.src == SRC_EXT_THREE |=> vec_reg == $past(vector_table_base_i) + 20'h00010)
		else $error("pin three offset wrong");
	chk_low_byte_first: assert property (@(posedge core_clk_i) disable iff (reset_i)
		state_reg == ST_FETCH && mem_ack_i && !word_reg && beat_reg == 2'h0
		|=> entry_reg[7:0] == $past(mem_rdata_i[7:0])) else $error("byte order wrong");

	cov_odd_base: cover property (@(posedge core_clk_i) disable iff (reset_i)
		done_o && !word_reg);
	cov_break_redirect: cover property (@(posedge core_clk_i) disable iff (reset_i)
		state_reg == ST_BREAK_CHK && mem_ack_i && mem_rdata_i[7:0] == BREAK_REDIRECT);
	cov_break_plain: cover property (@(posedge core_clk_i) disable iff (reset_i)
		state_reg == ST_BREAK_CHK && mem_ack_i && mem_rdata_i[7:0] != BREAK_REDIRECT);
	cov_even_reloc: cover property (@(posedge core_clk_i) disable iff (reset_i)
		accept && !is_fixed && !vector_table_base_i[0]);
	cov_fixed_done: cover property (@(posedge core_clk_i) disable iff (reset_i)
		done_o && vec_reg == FIX_NMI);
endmodule : ivam_vector_map

// ===== test/ivam_mem_model.sv
// Memory partner: answers vector reads after a random wait of 0 to max_wait_i.
// Assumes address and width stay stable until acknowledged.
`timescale 1ns/1ps
module ivam_mem_model (
	input  wire logic                core_clk_i,
	input  wire logic                reset_i,
	input  wire logic                mem_req_i,
	input  wire ivam_pkg::ivam_mem_t mem_i,
	input  wire logic [1:0]          max_wait_i,
	input  wire logic                break_ff_i,
	output logic                     mem_ack_o,
	output logic [15:0]              mem_rdata_o
);
	import ivam_pkg::*;
	logic [1:0] wait_reg;

	function automatic logic [7:0] byte_at(input logic [19:0] a);
		if (a == FIX_BREAK_FLAG) return break_ff_i ? 8'hff : 8'h00;
		return a[7:0] ^ {a[11:8], a[19:16]};
	endfunction : byte_at

	// Idle data lines toggle so stale values never look valid
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			mem_ack_o   <= 1'b0;
			wait_reg    <= 2'h0;
			mem_rdata_o <= 16'h0000;
		end else if (mem_req_i && !mem_ack_o && wait_reg != 2'h0) begin
			wait_reg    <= wait_reg - 2'h1;
			mem_rdata_o <= ~mem_rdata_o;
		end else if (mem_req_i && !mem_ack_o) begin
			mem_ack_o   <= 1'b1;
			mem_rdata_o <= {mem_i.word ? byte_at(mem_i.addr + 20'h1) : ~byte_at(mem_i.addr),
				byte_at(mem_i.addr)};
		end else begin
			mem_ack_o   <= 1'b0;
			wait_reg    <= 2'($urandom_range(0, int'(max_wait_i)));
			mem_rdata_o <= ~mem_rdata_o;
		end
	end
endmodule : ivam_mem_model

// ===== test/interrupt_vector_address_map_test.sv
// Self-checking bench for the vector map with a random-latency memory.
// Assumes the design and memory model run on one 200 MHz clock.
`timescale 1ns/1ps
module interrupt_vector_address_map_test;
	import ivam_pkg::*;
	logic                core_clk_i, reset_i, req_valid_i, req_ready_o, mem_req_o;
	logic                mem_ack_i, done_o, break_ff;
	ivam_req_t           req_i;
	ivam_mem_t           mem_o;
	logic [19:0]         base, vec_addr_o, target_o;
	logic [15:0]         mem_rdata_i;
	logic [1:0]          max_wait;
	int                  error_cnt, total_checks, cyc, lat, lat_even, i;
	localparam logic [19:0] FIX_TAB [11] = '{20'hfffdc, 20'hfffe0, 20'hfffe4, 20'hfffe8,
		20'hfffec, 20'hffff0, 20'hffff0, 20'hffff0, 20'hffff4, 20'hffff8, 20'hffffc};
	localparam logic [5:0] PER_NUM [28] = '{6'h1d, 6'h1e, 6'h1f, 6'h04, 6'h09, 6'h08,
		6'h0a, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h0f, 6'h10, 6'h10, 6'h11,
		6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c};

	ivam_vector_map dut_u (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
		.vector_table_base_i(base), .mem_req_o(mem_req_o), .mem_o(mem_o),
		.mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .done_o(done_o),
		.vec_addr_o(vec_addr_o), .target_o(target_o));
	ivam_mem_model mem_u (.core_clk_i(core_clk_i), .reset_i(reset_i), .mem_req_i(mem_req_o),
		.mem_i(mem_o), .max_wait_i(max_wait), .break_ff_i(break_ff), .mem_ack_o(mem_ack_i),
		.mem_rdata_o(mem_rdata_i));

	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	function automatic logic [7:0] exp_byte(input logic [19:0] a, input logic ff);
		if (a == FIX_BREAK_FLAG) return ff ? 8'hff : 8'h00;
		return a[7:0] ^ {a[11:8], a[19:16]};
	endfunction : exp_byte

	function automatic logic [19:0] exp_target(input logic [19:0] e, input logic ff);
		logic [7:0] hi;
		hi = exp_byte(e + 20'h2, ff);
		return {hi[3:0], exp_byte(e + 20'h1, ff), exp_byte(e, ff)};
	endfunction : exp_target

	task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One accepted request, then the answer is compared
	task automatic run(input ivam_src_t s, input logic [5:0] n, input logic [19:0] e);
		@(negedge core_clk_i);
		while (req_ready_o !== 1'b1) @(negedge core_clk_i);
		req_valid_i = 1'b1;
		req_i = '{src: s, swint_num: n};
		@(posedge core_clk_i);
		@(negedge core_clk_i);
		req_valid_i = 1'b0;
		req_i = '{src: ivam_src_t'(6'($urandom_range(0, 39))), swint_num: 6'($urandom)};
		lat = 0;
		while (done_o !== 1'b1) begin
			@(posedge core_clk_i);
			#1;
			lat++;
		end
		chk("vec_addr", e, vec_addr_o);
		chk("target", exp_target(e, break_ff), target_o);
		@(negedge core_clk_i);
	endtask : run

	// Peripheral sources over a slice of the number table
	task automatic peri(input int lo, input int hi);
		for (int k = lo; k <= hi; k++) begin
			base = 20'($urandom) & 20'hffffe;
			run(ivam_src_t'(6'(k + 12)), 6'h00, base + {12'h0, PER_NUM[k], 2'h0});
		end
	endtask : peri

	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end

	initial begin
		reset_i = 1'b1;
		req_valid_i = 1'b0;
		req_i = '0;
		base = 20'h00000;
		break_ff = 1'b0;
		max_wait = 2'h3;
		void'($urandom(7763));
		repeat (4) @(posedge core_clk_i);
		@(negedge core_clk_i);
		reset_i = 1'b0;
		for (i = 0; i < 11; i++) begin
			base = 20'($urandom) & 20'hffffe;
			run(ivam_src_t'(6'(i + 1)), 6'h00, FIX_TAB[i]);
		end
		$display("test fixed done");
		peri(0, 2);
		peri(3, 3);
		peri(4, 5);
		peri(6, 7);
		peri(8, 9);
		peri(10, 11);
		peri(12, 15);
		peri(16, 19);
		peri(20, 24);
		peri(25, 27);
		$display("test peripheral done");
		for (i = 0; i < 64; i++) begin
			base = (i == 63) ? 20'hfff01 : 20'($urandom);
			run(SRC_SWINT, 6'(i), base + 20'(i * 4));
		end
		$display("test software done");
		max_wait = 2'h0;
		base = 20'h12340;
		run(SRC_SWINT, 6'h05, 20'h12354);
		lat_even = lat;
		base = 20'h12341;
		run(SRC_SWINT, 6'h05, 20'h12355);
		chk("odd_slower", 20'h1, 20'(lat > lat_even));
		$display("test parity done");
		break_ff = 1'b1;
		for (i = 0; i < 4; i++) begin
			max_wait = 2'(i);
			base = 20'($urandom);
			run(SRC_BREAK, 6'($urandom), base);
		end
		$display("test break redirect done");
		summarize();
	end
endmodule : interrupt_vector_address_map_test
